// ### design/ptpci_pkg.sv
// constants and carrier types for the transmit command field intake
package ptpci_pkg;

    // register map, byte addresses on the configuration slave
    localparam logic [11:0] TX_CFG_OFFSET  = 12'h408;
    localparam logic [11:0] STATUS_OFFSET  = 12'h4F8;
    localparam int          ADDR_W         = 12;

    // transmitter configuration word layout
    localparam logic [31:0] TX_CFG_RESET   = 32'h1000_0000;
    localparam logic [31:0] TX_CFG_RW_MASK = 32'hFE40_0000;
    localparam int          INLINE_BIT     = 22;

    // status word layout
    localparam int          STAT_MODE_BIT  = 0;
    localparam int          STAT_BUSY_BIT  = 1;
    localparam int          STAT_CNT_LSB   = 16;

    // transmit user sideband layout
    localparam int          USER_W         = 128;
    localparam int          UNDERRUN_BIT   = 0;
    localparam int          CMD_LSB        = 64;
    localparam int          CMD_W          = 64;
    localparam int          TAG_LSB        = 48;
    localparam int          TAG_W          = 16;

    // in-line command field length in stream bytes
    localparam logic [3:0]  CMD_BYTES      = 4'h8;

    // buffering
    localparam int          FIFO_DEPTH     = 32;

    // AXI4-Lite responses
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_DECERR    = 2'h3;

    typedef enum logic [1:0]
    {
        SEL_NONE,
        SEL_TX_CFG,
        SEL_STATUS
    } ptpci_sel_type;

    typedef struct packed
    {
        logic       underrun;
        logic       last;
        logic [7:0] data;
    } ptpci_beat_type;

    typedef struct packed
    {
        logic [31:0] rsvd;
        logic [15:0] tag;
        logic [47:0] sec;
        logic [31:0] ns;
    } ptpci_stamp_type;

endpackage

// ### design/ptpci_intake.sv
// transmit command field intake with frame buffer and timestamp streams
`timescale 1ns/100ps

module ptpci_fifo
    import ptpci_pkg::*;
#(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // drain side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [PW:0]      count_q;
    logic [PW:0]      count_d;
    logic             push;
    logic             pop;

    // output register adds one slot beyond the array
    assign push    = in_valid && in_ready;
    assign pop     = (count_q != '0) && (!out_valid || out_ready);
    assign count_d = count_q + (PW+1)'(push) - (PW+1)'(pop);

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_q] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wr_ptr_q  <= '0;
            rd_ptr_q  <= '0;
            count_q   <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
            out_data  <= '0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_q + PW'(push);
            rd_ptr_q <= rd_ptr_q + PW'(pop);
            count_q  <= count_d;
            // registered full flag, so ready is honest one cycle early
            in_ready <= (count_d < (PW+1)'(DEPTH));
            if (pop)
                out_data <= mem[rd_ptr_q];
            if (pop)
                out_valid <= 1'b1;
            else if (out_ready)
                out_valid <= 1'b0;
        end
    end

    fifo_no_overflow_a: assert property (@(posedge clk) disable iff (sys_rst)
        count_q <= (PW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule

module ptpci_intake
    import ptpci_pkg::*;
#(
    parameter bit PTP_PRESENT = 1'b1
)
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                sys_rst,
    // configuration slave
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // transmit stream from the client
    input  wire logic [7:0]          s_axis_tx_tdata,
    input  wire logic [USER_W-1:0]   s_axis_tx_tuser,
    input  wire logic                s_axis_tx_tlast,
    input  wire logic                s_axis_tx_tvalid,
    output logic                     s_axis_tx_tready,
    // frame data toward the MAC transmitter
    output logic [7:0]               mac_tx_tdata,
    output logic                     mac_tx_tuser,
    output logic                     mac_tx_tlast,
    output logic                     mac_tx_tvalid,
    input  wire logic                mac_tx_tready,
    // extracted command field
    output logic [CMD_W-1:0]         cmd_field,
    output logic                     cmd_valid,
    // system timer
    input  wire logic [47:0]         timer_sec,
    input  wire logic [31:0]         timer_ns,
    // receive data from the MAC and toward the client
    input  wire logic [7:0]          mac_rx_tdata,
    input  wire logic                mac_rx_tlast,
    input  wire logic                mac_rx_tvalid,
    output logic [7:0]               m_axis_rx_tdata,
    output logic                     m_axis_rx_tlast,
    output logic                     m_axis_rx_tvalid,
    // timestamp streams
    output logic [127:0]             tx_stamp_stream_out_tdata,
    output logic                     tx_stamp_stream_out_tvalid,
    output logic [127:0]             rx_stamp_stream_out_tdata,
    output logic                     rx_stamp_stream_out_tvalid
);
    typedef enum logic [1:0]
    {
        ST_IDLE,
        ST_CMD,
        ST_DATA
    } ptpci_state_type;

    function automatic ptpci_sel_type decode(input logic [ADDR_W-1:0] addr);
        if (addr == TX_CFG_OFFSET)
            return SEL_TX_CFG;
        else if (addr == STATUS_OFFSET)
            return SEL_STATUS;
        else
            return SEL_NONE;
    endfunction

    ptpci_state_type  state_q;
    ptpci_state_type  state_d;
    logic [31:0]      tx_cfg_q;
    logic             inline_q;
    logic [3:0]       cmd_cnt_q;
    logic [CMD_W-1:0] cmd_shift_q;
    logic [15:0]      frame_cnt_q;
    logic             rx_in_frame_q;

    // register bus decode
    ptpci_sel_type    wr_sel;
    ptpci_sel_type    rd_sel;
    logic             wr_go;
    logic             rd_go;
    logic [31:0]      wmask;
    logic [31:0]      status_word;
    logic [31:0]      rd_word;

    assign wr_go  = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    assign rd_go  = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
    assign wr_sel = decode(s_axi_awaddr);
    assign rd_sel = decode(s_axi_araddr);
    assign wmask  = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                     {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}} & TX_CFG_RW_MASK;

    assign status_word = {frame_cnt_q, 14'h0000, (state_q != ST_IDLE), inline_q};
    assign rd_word     = (rd_sel == SEL_TX_CFG) ? tx_cfg_q :
                         (rd_sel == SEL_STATUS) ? status_word : 32'h0000_0000;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
        end
        else
        begin
            s_axi_awready <= wr_go;
            s_axi_wready  <= wr_go;
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_arready <= rd_go;
            if (rd_go)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= (rd_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // configuration word, reserved bits stay zero
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            tx_cfg_q <= TX_CFG_RESET;
        else if (wr_go && wr_sel == SEL_TX_CFG)
            tx_cfg_q <= (tx_cfg_q & ~wmask) | (s_axi_wdata & wmask);
    end

    // transmit intake
    ptpci_beat_type beat_in;
    ptpci_beat_type beat_out;
    logic           fifo_ready;
    logic           accept;
    logic           first_beat;
    logic           cmd_beat;
    logic           push;
    logic           mode_next;

    assign accept     = s_axis_tx_tvalid && s_axis_tx_tready;
    // no timestamp build, bit has no effect
    assign mode_next  = PTP_PRESENT && tx_cfg_q[INLINE_BIT];
    // idle in in-line mode already takes byte 0 as field, so back-to-back frames lose nothing
    assign cmd_beat   = inline_q && (state_q != ST_DATA);
    assign first_beat = accept && (state_q == ST_IDLE) && !inline_q;
    // in out-of-band mode every byte goes to the MAC
    assign push       = accept && !cmd_beat;
    // underrun flag travels with the byte; bits 63:1 unused
    assign beat_in    = '{underrun: s_axis_tx_tuser[UNDERRUN_BIT],
                          last:     s_axis_tx_tlast,
                          data:     s_axis_tx_tdata};
    assign s_axis_tx_tready = fifo_ready;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:
                if (accept && !s_axis_tx_tlast)
                    state_d = inline_q ? ST_CMD : ST_DATA;
            ST_CMD:
                if (accept && s_axis_tx_tlast)
                    state_d = ST_IDLE;
                else if (accept && cmd_cnt_q == CMD_BYTES - 4'h1)
                    state_d = ST_DATA;
            ST_DATA:
                if (accept && s_axis_tx_tlast)
                    state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_q     <= ST_IDLE;
            inline_q    <= 1'b0;
            cmd_cnt_q   <= 4'h0;
            cmd_shift_q <= '0;
            frame_cnt_q <= 16'h0000;
        end
        else
        begin
            state_q <= state_d;
            if (state_d == ST_IDLE)
                inline_q <= mode_next;
            // in-line field, first byte lands in bits 7:0
            if (state_d == ST_IDLE)
                cmd_cnt_q <= 4'h0;
            else if (cmd_beat && accept)
                cmd_cnt_q <= cmd_cnt_q + 4'h1;
            if (cmd_beat && accept)
                cmd_shift_q <= {s_axis_tx_tdata, cmd_shift_q[CMD_W-1:8]};
            if (push && s_axis_tx_tlast)
                frame_cnt_q <= frame_cnt_q + 16'h0001;
        end
    end

    ptpci_fifo #(
        .WIDTH ($bits(ptpci_beat_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_data   (beat_in),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .out_data  (beat_out),
        .out_valid (mac_tx_tvalid),
        .out_ready (mac_tx_tready)
    );

    assign mac_tx_tdata = beat_out.data;
    assign mac_tx_tlast = beat_out.last;
    assign mac_tx_tuser = beat_out.underrun;

    // command field capture and transmit stamp
    logic            inline_done;
    logic [CMD_W-1:0] cmd_now;

    assign inline_done = cmd_beat && accept && !s_axis_tx_tlast
                         && (cmd_cnt_q == CMD_BYTES - 4'h1);
    assign cmd_now     = inline_done ? {s_axis_tx_tdata, cmd_shift_q[CMD_W-1:8]}
                                     : s_axis_tx_tuser[CMD_LSB +: CMD_W];

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cmd_field                  <= '0;
            cmd_valid                  <= 1'b0;
            tx_stamp_stream_out_tdata  <= '0;
            tx_stamp_stream_out_tvalid <= 1'b0;
        end
        else
        begin
            // sideband field used only out-of-band, on the first beat
            cmd_valid                  <= PTP_PRESENT && (first_beat || inline_done);
            tx_stamp_stream_out_tvalid <= PTP_PRESENT && (first_beat || inline_done);
            if (first_beat || inline_done)
            begin
                cmd_field <= cmd_now;
                // tag copied into stamp bits 95:80
                tx_stamp_stream_out_tdata <= ptpci_stamp_type'{rsvd: 32'h0000_0000,
                                               tag:  cmd_now[TAG_LSB +: TAG_W],
                                               sec:  timer_sec,
                                               ns:   timer_ns};
            end
        end
    end

    // receive data and receive stamp on first beat
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            m_axis_rx_tdata            <= 8'h00;
            m_axis_rx_tlast            <= 1'b0;
            m_axis_rx_tvalid           <= 1'b0;
            rx_in_frame_q              <= 1'b0;
            rx_stamp_stream_out_tdata  <= '0;
            rx_stamp_stream_out_tvalid <= 1'b0;
        end
        else
        begin
            m_axis_rx_tdata            <= mac_rx_tdata;
            m_axis_rx_tlast            <= mac_rx_tlast;
            m_axis_rx_tvalid           <= mac_rx_tvalid;
            if (mac_rx_tvalid)
                rx_in_frame_q <= !mac_rx_tlast;
            rx_stamp_stream_out_tvalid <= PTP_PRESENT && mac_rx_tvalid && !rx_in_frame_q;
            if (mac_rx_tvalid && !rx_in_frame_q)
                rx_stamp_stream_out_tdata <= ptpci_stamp_type'{rsvd: 32'h0000_0000, tag: 16'h0000,
                                               sec: timer_sec, ns: timer_ns};
        end
    end

    // checks
    sequence inline_field_s;
        cmd_beat && accept && cmd_cnt_q == 4'h7 && !s_axis_tx_tlast;
    endsequence

    sequence oob_first_s;
        accept && state_q == ST_IDLE && !inline_q;
    endsequence

    oob_cmd_take_a: assert property (@(posedge clk) disable iff (sys_rst)
        oob_first_s |=> cmd_valid && cmd_field == $past(s_axis_tx_tuser[127:64]))
        else $error("out-of-band field not captured");
    // in-line bytes never reach the MAC
    inline_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_beat |-> !push)
        else $error("command byte pushed as data");
    inline_done_a: assert property (@(posedge clk) disable iff (sys_rst)
        inline_field_s |=> cmd_valid ##0 state_q == ST_DATA)
        else $error("in-line field not completed");
    // out-of-band byte goes straight to buffer
    oob_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
        (accept && !inline_q && state_q != ST_CMD) |-> push)
        else $error("out-of-band byte lost");
    cfg_reset_a: assert property (@(posedge clk)
        $past(sys_rst) |-> tx_cfg_q == TX_CFG_RESET && !inline_q)
        else $error("configuration reset wrong");
    mode_stable_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q != ST_IDLE && $past(state_q) != ST_IDLE) |-> $stable(inline_q))
        else $error("mode changed mid-frame");
    stamp_tag_a: assert property (@(posedge clk) disable iff (sys_rst)
        tx_stamp_stream_out_tvalid |-> tx_stamp_stream_out_tdata[95:80] == cmd_field[63:48])
        else $error("stamp tag mismatch");
    underrun_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
        push |-> beat_in.underrun == s_axis_tx_tuser[0])
        else $error("underrun flag dropped");
    bus_resp_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr_go |=> s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write response missing");
    // receive stamp on first receive beat
    rx_stamp_a: assert property (@(posedge clk) disable iff (sys_rst)
        (mac_rx_tvalid && !rx_in_frame_q) |=> rx_stamp_stream_out_tvalid == PTP_PRESENT)
        else $error("receive stamp missing");
endmodule

// ### bench/ptpci_client_model.sv
// client transmit model feeding frames into the intake stream slave
`timescale 1ns/100ps
module ptpci_client_model
    import ptpci_pkg::*;
(
    // control from the bench
    input  wire logic              clk,
    input  wire logic              go,
    input  wire logic              inl,
    input  wire logic [63:0]       cmd,
    input  wire logic [7:0]        len,
    input  wire logic              und,
    output logic                   busy,
    // stream toward the intake
    output logic [7:0]             tdata,
    output logic [USER_W-1:0]      tuser,
    output logic                   tlast,
    output logic                   tvalid,
    input  wire logic              tready
);
    int k;
    int n;
    initial
    begin
        busy = 1'b0;
        tdata = 8'h00;
        tuser = '0;
        tlast = 1'b0;
        tvalid = 1'b0;
        forever
        begin
            @(posedge clk);
            if (go)
            begin
                busy = 1'b1;
                n = inl ? len + 8 : len;
                for (k = 0; k < n; k++)
                begin
                    #1;
                    tvalid = 1'b1;
                    tdata = (inl && k < 8) ? cmd[8*(k%8) +: 8] : 8'(inl ? k - 8 : k);
                    tuser[127:64] = (!inl && k == 0) ? cmd : ~cmd;
                    tuser[63:0] = {{63{k[0]}}, und && k == n - 1};
                    tlast = (k == n - 1);
                    while (!tready) @(posedge clk) #1;
                    @(posedge clk);
                end
                #1;
                // released lines stop showing the last byte
                tvalid = 1'b0;
                tdata = ~tdata;
                tuser = ~tuser;
                tlast = 1'b0;
                busy = 1'b0;
            end
        end
    end
endmodule

// ### bench/ptpci_intake_tb.sv
// self-checking bench for the transmit command field intake
`timescale 1ns/100ps
module ptpci_intake_tb
    import ptpci_pkg::*;
;
    logic clk, sys_rst, go, inl, und, busy, mac_rdy;
    logic awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_v;
    logic [1:0] bresp, rresp, resp;
    logic [63:0] cmd, cmd_field, cmd_q;
    logic [7:0] len, tdata, mac_d;
    logic [USER_W-1:0] tuser;
    logic tlast, tvalid, tready, mac_u, mac_l, mac_v, cmd_valid, sv;
    logic [127:0] sd;
    logic [63:0] tag_q;
    logic [31:0] timer_ns = 32'h0;
    logic [9:0] mq[$];
    logic [7:0] rx_d, rx_od;
    logic rx_v, rx_l, rx_ov, rx_ol, rs_v;
    logic [127:0] rs_d;
    int mismatches = 0;
    int compares = 0;
    int ncmd = 0;

    ptpci_intake ptpci_intake_inst (
        .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .s_axis_tx_tdata(tdata), .s_axis_tx_tuser(tuser), .s_axis_tx_tlast(tlast),
        .s_axis_tx_tvalid(tvalid), .s_axis_tx_tready(tready), .mac_tx_tdata(mac_d),
        .mac_tx_tuser(mac_u), .mac_tx_tlast(mac_l), .mac_tx_tvalid(mac_v),
        .mac_tx_tready(mac_rdy), .cmd_field(cmd_field), .cmd_valid(cmd_valid),
        .timer_sec(48'h0000_0000_0012), .timer_ns(timer_ns), .mac_rx_tdata(rx_d),
        .mac_rx_tlast(rx_l), .mac_rx_tvalid(rx_v), .m_axis_rx_tdata(rx_od),
        .m_axis_rx_tlast(rx_ol), .m_axis_rx_tvalid(rx_ov), .tx_stamp_stream_out_tdata(sd),
        .tx_stamp_stream_out_tvalid(sv), .rx_stamp_stream_out_tdata(rs_d),
        .rx_stamp_stream_out_tvalid(rs_v)
    );

    ptpci_client_model ptpci_client_model_inst (
        .clk(clk), .go(go), .inl(inl), .cmd(cmd), .len(len), .und(und), .busy(busy),
        .tdata(tdata), .tuser(tuser), .tlast(tlast), .tvalid(tvalid), .tready(tready)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        timer_ns <= timer_ns + 32'h1;
        if (mac_v === 1'b1 && mac_rdy)
            mq.push_back({mac_l, mac_u, mac_d});
        if (cmd_valid === 1'b1)
        begin
            cmd_q = cmd_field;
            ncmd++;
        end
        if (sv === 1'b1)
            tag_q = sd[95:32];
    end

    task give_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input bit ok, input string m);
        compares++;
        if (!ok)
        begin
            mismatches++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask

    // a used-up bound ends the run at once
    task hang(input int t, input int lim);
        if (t >= lim)
        begin
            chk(1'b0, "wait ran out");
            give_verdict();
        end
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        int t;
        @(posedge clk);
        #1;
        awaddr = a;
        wdata = d;
        awvalid = 1'b1;
        wvalid = 1'b1;
        for (t = 0; t < 20 && awready !== 1'b1; t++) @(posedge clk) #1;
        hang(t, 20);
        chk(bvalid === 1'b1, "no write answer");
        resp = bresp;
        @(posedge clk);
        #1;
        awvalid = 1'b0;
        wvalid = 1'b0;
    endtask

    task rd(input logic [11:0] a);
        int t;
        @(posedge clk);
        #1;
        araddr = a;
        arvalid = 1'b1;
        for (t = 0; t < 20 && arready !== 1'b1; t++) @(posedge clk) #1;
        hang(t, 20);
        chk(rvalid === 1'b1, "no read answer");
        rd_v = rdata;
        resp = rresp;
        @(posedge clk);
        #1;
        arvalid = 1'b0;
    endtask

    task launch(input logic i, input logic [63:0] c, input logic [7:0] l, input logic u);
        mq.delete();
        ncmd = 0;
        @(posedge clk);
        #1;
        inl = i;
        cmd = c;
        len = l;
        und = u;
        go = 1'b1;
        @(posedge clk);
        #1;
        go = 1'b0;
    endtask

    // command field and stamp tag checked, then every byte at the mac side
    task judge(input logic [63:0] c, input logic [7:0] l, input logic u);
        int t;
        for (t = 0; t < 400 && (busy || mq.size() < l); t++) @(posedge clk) #1;
        hang(t, 400);
        repeat (4) @(posedge clk);
        #1;
        chk(ncmd == 1 && cmd_q === c, "command field");
        chk(tag_q === {c[63:48], 48'h0000_0000_0012}, "stamp tag");
        chk(mq.size() == l, "frame length");
        for (t = 0; t < mq.size(); t++)
            chk(mq[t] === {t == l - 1, u && t == l - 1, 8'(t)}, "frame byte");
    endtask

    task frame(input logic i, input logic [63:0] c, input logic [7:0] l, input logic u);
        launch(i, c, l, u);
        judge(c, l, u);
    endtask

    task t_regs;
        rd(TX_CFG_OFFSET);
        chk(rd_v === TX_CFG_RESET && resp === RESP_OKAY, "config reset");
        wr(TX_CFG_OFFSET, 32'hFFFF_FFFF);
        rd(TX_CFG_OFFSET);
        chk(rd_v === TX_CFG_RW_MASK, "config writable bits");
        rd(12'h400);
        chk(rd_v === 32'h0 && resp === RESP_DECERR, "unmapped read");
        wr(12'h400, 32'hFFFF_FFFF);
        chk(resp === RESP_DECERR, "unmapped write");
        wr(TX_CFG_OFFSET, TX_CFG_RESET);
        $display("test registers done");
    endtask

    task t_frames;
        frame(1'b0, 64'h1234_5678_9ABC_DEF0, 8'h05, 1'b1);
        frame(1'b0, 64'hFEDC_0000_1111_2222, 8'h01, 1'b0);
        wr(TX_CFG_OFFSET, TX_CFG_RESET | 32'h0040_0000);
        rd(STATUS_OFFSET);
        chk(rd_v === 32'h0002_0001 && resp === RESP_OKAY, "status word");
        frame(1'b1, 64'hA5C3_9617_2E4B_D80F, 8'h04, 1'b0);
        frame(1'b1, 64'h0F1E_2D3C_4B5A_6978, 8'h01, 1'b1);
        wr(TX_CFG_OFFSET, TX_CFG_RESET);
        frame(1'b0, 64'h5566_7788_99AA_BBCC, 8'h03, 1'b0);
        $display("test frames done");
    endtask

    // receive bytes mirrored one cycle late, a stamp on each frame's first byte
    task t_rx;
        int k;
        for (k = 0; k < 6; k++)
        begin
            @(posedge clk);
            #1;
            if (k > 0)
                chk(rx_ov === (k < 5) && (k == 5 || rx_od === 8'(8'h2F + k)), "rx data");
            chk(rs_v === (k == 1 || k == 4) && rx_ol === (k == 3 || k == 4), "rx stamp");
            chk(rs_v !== 1'b1 || rs_d[95:32] === 64'h12, "rx stamp word");
            {rx_v, rx_l, rx_d} = {k < 4, k == 2 || k == 3, 8'(8'h30 + k)};
        end
        $display("test receive done");
    endtask

    // stalled mac side must make the stream refuse, then drain intact
    task t_fill;
        mac_rdy = 1'b0;
        launch(1'b0, 64'hC0DE_CAFE_0000_0001, 8'h28, 1'b0);
        repeat (80) @(posedge clk);
        #1;
        chk(tready === 1'b0 && mq.size() == 0, "buffer never refused");
        mac_rdy = 1'b1;
        judge(64'hC0DE_CAFE_0000_0001, 8'h28, 1'b0);
        $display("test fill done");
    endtask

    initial
    begin
        sys_rst = 1'b1;
        {awvalid, wvalid, arvalid, go, inl, und} = '0;
        {awaddr, araddr, wdata, cmd, len} = '0;
        {rx_v, rx_l, rx_d} = '0;
        mac_rdy = 1'b1;
        repeat (16) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_regs();
        t_rx();
        t_frames();
        t_fill();
        give_verdict();
    end
endmodule
